//--- hw/ucr_consts.svh
// Constants of the USB common control register bank.
`ifndef UCR_CONSTS_SVH
`define UCR_CONSTS_SVH
`define UCR_WIN_LO 16'h6200
`define UCR_WIN_HI 16'h622b
`define UCR_OFS_ADDR 16'h6200
`define UCR_OFS_POW 16'h6201
`define UCR_OFS_INFLG 16'h6202
`define UCR_OFS_OUTFLG 16'h6204
`define UCR_OFS_COMFLG 16'h6206
`define UCR_OFS_INEN 16'h6207
`define UCR_OFS_SEL 16'h620e
`define UCR_BIT_UPD 7
`define UCR_BIT_ISOWAIT 7
`define UCR_BIT_RST 3
`define UCR_BIT_RESUME 2
`define UCR_BIT_SUSP 1
`define UCR_BIT_SUSPEN 0
`define UCR_COM_SOF 3
`define UCR_COM_RST 2
`define UCR_COM_WAKE 1
`define UCR_COM_SLEEP 0
`define UCR_INEN_RST 6'h3f
`define UCR_OUT_MASK 8'h3e
`define UCR_IDLE_US 3000
`define UCR_CLK_MHZ 100
`endif

//--- hw/ucr_pkg.sv
// Types of the USB common control register bank.
package ucr_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ucr_bus_s;
  typedef struct packed {
    logic sof;
    logic busReset;
    logic resumeSeen;
    logic busIdle;
    logic addrApplied;
  } ucr_link_s;
  typedef enum logic [1:0] {ST_AWAKE, ST_SLEEP} ucr_pwr_e;
endpackage

//--- hw/ucr_regs.sv
// USB common control register bank with suspend detect and event flags.
`timescale 1ns/1ps
`include "ucr_consts.svh"

// Function
// [RULE1] Decode registers only inside the 0x6200 to 0x622b data space window.
// [RULE2] Endpoint select output steers every indexed register access.
// [RULE3] Deep power mode entry resets all registers and flushes FIFOs.
// [RULE4] Address pending bit sets on write, clears when address takes effect.
// [RULE5] Isochronous hold bit makes loaded iso IN answer zero length until SOF.
// [RULE6] Bus reset status bit follows reset signalling on the bus.
// [RULE7] Firmware holds resume drive one to fifteen milliseconds.
// [RULE8] Suspended bit clears on common flag read or resume drive set.
// [RULE9] With suspend enabled, three milliseconds idle enters suspend.
// [RULE10] IN flags in bits 5 to 0, cleared on read.
// [RULE11] OUT flags in bits 5 to 1, others read zero, cleared on read.
// [RULE12] Common flags SOF, reset, resume, suspend in bits 3 to 0, read clears.
// [RULE13] IN enable mask bits 5 to 0, read/write, reset to one.
// [RULE14] Software writes zeros to the two upper enable mask bits.
// [RULE15] Bus reset clears function address and endpoint select, flushes FIFOs.
// [RULE16] Flags set regardless of mask; mask gates only the interrupt request.
// [RULE17] Suspend entry sets the suspend event flag.
// [RULE18] An event in the clearing read cycle keeps its flag set.
module ucr_regs #(
  parameter int IDLE_CYC = `UCR_IDLE_US * `UCR_CLK_MHZ
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic deepPowerEntry,
  // CPU data space access
  input wire ucr_pkg::ucr_bus_s cpuBus,
  output logic [7:0] rdData,
  // Events from the USB engine
  input wire ucr_pkg::ucr_link_s link,
  input wire logic [5:0] inEvents,
  input wire logic [5:0] outEvents,
  input wire logic isoInLoaded,
  // Control towards the USB engine
  output logic [6:0] deviceAddress,
  output logic [3:0] endpointSelect,
  output logic isoZeroLength,
  output logic resumeDrive,
  output logic fifoFlush,
  output logic suspended,
  output logic intRequest
);
  // ------------------------------------------------------------
  // Reset synchroniser
  // ------------------------------------------------------------
  logic rstMeta_reg, rstSync_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end
  wire rstAny = !rstSync_reg;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  wire inWin = cpuBus.addr >= `UCR_WIN_LO && cpuBus.addr <= `UCR_WIN_HI; // RULE1
  wire wrEn = cpuBus.wr && inWin;
  wire rdEn = cpuBus.rd && inWin;
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = a == ofs;
  endfunction
  wire wrAddr = wrEn && hit(cpuBus.addr, `UCR_OFS_ADDR);
  wire wrPow = wrEn && hit(cpuBus.addr, `UCR_OFS_POW);
  wire wrInEn = wrEn && hit(cpuBus.addr, `UCR_OFS_INEN);
  wire wrSel = wrEn && hit(cpuBus.addr, `UCR_OFS_SEL);
  wire rdIn = rdEn && hit(cpuBus.addr, `UCR_OFS_INFLG);
  wire rdOut = rdEn && hit(cpuBus.addr, `UCR_OFS_OUTFLG);
  wire rdCom = rdEn && hit(cpuBus.addr, `UCR_OFS_COMFLG);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [6:0] addr_reg;
  logic pend_reg;
  logic [3:0] sel_reg;
  logic isoWait_reg, resume_reg, suspEn_reg, busRst_reg;
  logic [5:0] inFlg_reg, inEn_reg;
  logic [7:0] outFlg_reg;
  logic [3:0] comFlg_reg;
  logic [7:0] rd_reg;
  logic flush_reg, irq_reg, isoHold_reg;
  // Suspended status has its own flop so that the output is registered.
  logic susp_reg;
  logic [31:0] idle_reg;
  ucr_pkg::ucr_pwr_e pwr_reg;

  // Deep power entry takes the synchronised reset branch: the bank clears and the FIFO flush rises.
  wire clrAll = rstAny || deepPowerEntry; // RULE3
  // The idle counter saturates, so a long idle stretch never wraps.
  wire idleDone = link.busIdle && idle_reg >= 32'(IDLE_CYC - 1);
  wire enterSleep = suspEn_reg && pwr_reg == ucr_pkg::ST_AWAKE && idleDone; // RULE9
  wire wakeNow = rdCom || (wrPow && cpuBus.wdata[`UCR_BIT_RESUME]) || link.resumeSeen; // RULE8
  // Suspend is entered again at once if the bus stays idle after a wake cause.
  wire ucr_pkg::ucr_pwr_e pwrNext = enterSleep ? ucr_pkg::ST_SLEEP :
    ((wakeNow || !suspEn_reg || link.busReset) ? ucr_pkg::ST_AWAKE : pwr_reg); // RULE8 RULE9

  // An event in the clearing read cycle wins, so no event is lost.
  wire [3:0] comEv = {link.sof, link.busReset, link.resumeSeen && !link.busReset, enterSleep}; // RULE12 RULE17
  wire [5:0] inNext = (rdIn ? 6'h00 : inFlg_reg) | inEvents; // RULE10 RULE16 RULE18
  wire [7:0] outNext = ((rdOut ? 8'h00 : outFlg_reg) | {2'b00, outEvents}) & `UCR_OUT_MASK; // RULE11
  wire [3:0] comNext = (rdCom ? 4'h0 : comFlg_reg) | comEv; // RULE12 RULE18

  wire [7:0] powRd = {isoWait_reg, 3'b000, busRst_reg, resume_reg,
                      pwr_reg == ucr_pkg::ST_SLEEP && suspEn_reg, suspEn_reg};
  // Unmapped and out-of-window reads return zero.
  logic [7:0] rdNext;
  always_comb begin
    rdNext = 8'h00;
    if (rdEn) begin
      case (cpuBus.addr)
        `UCR_OFS_ADDR: rdNext = {pend_reg, addr_reg}; // RULE4
        `UCR_OFS_POW: rdNext = powRd; // RULE6
        `UCR_OFS_INFLG: rdNext = {2'b00, inFlg_reg};
        `UCR_OFS_OUTFLG: rdNext = outFlg_reg;
        `UCR_OFS_COMFLG: rdNext = {4'h0, comFlg_reg};
        `UCR_OFS_INEN: rdNext = {2'b00, inEn_reg}; // RULE14
        `UCR_OFS_SEL: rdNext = {4'h0, sel_reg};
        default: rdNext = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= 7'h00;
      pend_reg <= 1'b0;
      sel_reg <= 4'h0;
      isoWait_reg <= 1'b0;
      resume_reg <= 1'b0;
      suspEn_reg <= 1'b0;
      busRst_reg <= 1'b0;
      inFlg_reg <= 6'h00;
      inEn_reg <= `UCR_INEN_RST;
      outFlg_reg <= 8'h00;
      comFlg_reg <= 4'h0;
      rd_reg <= 8'h00;
      flush_reg <= 1'b0;
      irq_reg <= 1'b0;
      isoHold_reg <= 1'b0;
      idle_reg <= 32'h0;
      pwr_reg <= ucr_pkg::ST_AWAKE;
      susp_reg <= 1'b0;
    end else if (clrAll) begin
      addr_reg <= 7'h00;
      pend_reg <= 1'b0;
      sel_reg <= 4'h0;
      isoWait_reg <= 1'b0;
      resume_reg <= 1'b0;
      suspEn_reg <= 1'b0;
      busRst_reg <= 1'b0;
      inFlg_reg <= 6'h00;
      inEn_reg <= `UCR_INEN_RST;
      outFlg_reg <= 8'h00;
      comFlg_reg <= 4'h0;
      rd_reg <= 8'h00;
      flush_reg <= 1'b1; // RULE3
      irq_reg <= 1'b0;
      isoHold_reg <= 1'b0;
      idle_reg <= 32'h0;
      pwr_reg <= ucr_pkg::ST_AWAKE;
      susp_reg <= 1'b0;
    end else begin
      rd_reg <= rdNext;
      busRst_reg <= link.busReset; // RULE6
      inFlg_reg <= inNext;
      outFlg_reg <= outNext;
      comFlg_reg <= comNext;
      flush_reg <= link.busReset; // RULE15
      irq_reg <= |(inNext & inEn_reg); // RULE16
      idle_reg <= link.busIdle ? (idleDone ? idle_reg : idle_reg + 32'h1) : 32'h0;
      if (link.busReset) begin
        addr_reg <= 7'h00; // RULE15
        sel_reg <= 4'h0;
        pend_reg <= 1'b0;
      end else begin
        if (wrAddr) begin
          addr_reg <= cpuBus.wdata[6:0];
          pend_reg <= 1'b1; // RULE4
        end else if (link.addrApplied) begin
          pend_reg <= 1'b0; // RULE4
        end
        if (wrSel) begin
          sel_reg <= cpuBus.wdata[3:0]; // RULE2
        end
      end
      if (wrPow) begin
        isoWait_reg <= cpuBus.wdata[`UCR_BIT_ISOWAIT];
        resume_reg <= cpuBus.wdata[`UCR_BIT_RESUME]; // RULE7
        suspEn_reg <= cpuBus.wdata[`UCR_BIT_SUSPEN];
      end
      if (wrInEn) begin
        inEn_reg <= cpuBus.wdata[5:0]; // RULE13
      end
      pwr_reg <= pwrNext; // RULE9 RULE17
      susp_reg <= pwrNext == ucr_pkg::ST_SLEEP; // RULE8
      if (link.sof) begin
        isoHold_reg <= 1'b0; // RULE5
      end else if (isoWait_reg && isoInLoaded) begin
        isoHold_reg <= 1'b1; // RULE5
      end
    end
  end

  assign rdData = rd_reg;
  assign deviceAddress = addr_reg;
  assign endpointSelect = sel_reg; // RULE2
  assign isoZeroLength = isoHold_reg;
  assign resumeDrive = resume_reg;
  assign fifoFlush = flush_reg;
  assign suspended = susp_reg;
  assign intRequest = irq_reg;
endmodule

//--- verif/ucr_monitor.sv
// Port assertions for the USB common control register bank.
`timescale 1ns/1ps
`include "ucr_consts.svh"
module ucr_regs_monitor (
  // Ports of the register bank except outEvents and isoInLoaded, all watched as inputs
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic deepPowerEntry,
  input wire ucr_pkg::ucr_bus_s cpuBus,
  input wire logic [7:0] rdData,
  input wire ucr_pkg::ucr_link_s link,
  input wire logic [5:0] inEvents,
  input wire logic [6:0] deviceAddress,
  input wire logic [3:0] endpointSelect,
  input wire logic isoZeroLength,
  input wire logic resumeDrive,
  input wire logic fifoFlush,
  input wire logic suspended,
  input wire logic intRequest
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire powWr = cpuBus.wr && cpuBus.addr == `UCR_OFS_POW;
  wire adrWr = cpuBus.wr && cpuBus.addr == `UCR_OFS_ADDR;
  outside_read_a: assert property (cpuBus.rd && cpuBus.addr > `UCR_WIN_HI |=> rdData == 8'h00)
    else $error("read outside the window returned data");
  address_write_a: assert property (adrWr && !link.busReset && !deepPowerEntry
    |=> deviceAddress == $past(cpuBus.wdata[6:0])) else $error("address write lost");
  bus_reset_a: assert property (link.busReset |-> ##[1:2] (fifoFlush && deviceAddress == 0
    && endpointSelect == 0)) else $error("bus reset left state behind");
  deep_power_a: assert property (deepPowerEntry |-> ##[1:3] (deviceAddress == 0
    && endpointSelect == 0 && !resumeDrive && !suspended)) else $error("deep entry kept state");
  resume_drive_a: assert property (powWr && cpuBus.wdata[2] |=> resumeDrive && !suspended)
    else $error("resume write not taken");
  flag_read_a: assert property (cpuBus.rd && cpuBus.addr == `UCR_OFS_COMFLG |=> !suspended)
    else $error("suspended kept after common flag read");
  idle_entry_a: assert property ($rose(suspended) |-> $past(link.busIdle))
    else $error("suspend entered without idle bus");
  sof_release_a: assert property (link.sof |=> !isoZeroLength)
    else $error("zero length kept after frame start");
  irq_cause_a: assert property ($rose(intRequest) |-> $past(|inEvents) || $past(cpuBus.wr
    && cpuBus.addr == `UCR_OFS_INEN)) else $error("interrupt request without cause");
  cover property ($rose(suspended));
  cover property (link.busReset);
  cover property (cpuBus.rd && |inEvents);
endmodule
bind ucr_regs ucr_regs_monitor u_ucr_regs_monitor (.sys_clk(sys_clk), .rst_n(rst_n),
  .deepPowerEntry(deepPowerEntry), .cpuBus(cpuBus), .rdData(rdData), .link(link),
  .inEvents(inEvents), .deviceAddress(deviceAddress), .endpointSelect(endpointSelect),
  .isoZeroLength(isoZeroLength), .resumeDrive(resumeDrive), .fifoFlush(fifoFlush),
  .suspended(suspended), .intRequest(intRequest));

//--- verif/ucr_usb_host.sv
// Behavioural USB bus side that drives the link and endpoint event lines.
`timescale 1ns/1ps
module ucr_usb_host (
  // Clock
  input wire logic sys_clk,
  // Bus conditions and endpoint events towards the register bank
  output ucr_pkg::ucr_link_s link,
  output logic [5:0] inEvents,
  output logic [5:0] outEvents,
  output logic isoInLoaded
);
  initial begin
    link = '0;
    inEvents = 6'h00;
    outEvents = 6'h00;
    isoInLoaded = 1'b0;
  end
  // Endpoint events change at once; callers make the call just after a falling edge.
  task automatic set_events(input logic [5:0] i, input logic [5:0] o, input logic iso);
    inEvents = i;
    outEvents = o;
    isoInLoaded = iso;
  endtask
  // Levels change after the falling edge so the block samples them cleanly.
  task automatic put(input ucr_pkg::ucr_link_s v);
    @(negedge sys_clk);
    link = v;
  endtask
endmodule

//--- verif/test_usb_common_control_registers.sv
// Self-checking bench for the USB common control register bank.
`timescale 1ns/1ps
`include "ucr_consts.svh"
module test_usb_common_control_registers;
  logic sys_clk = 0, rst_n = 0, deepPowerEntry = 0, isoInLoaded;
  ucr_pkg::ucr_bus_s cpuBus = '0;
  ucr_pkg::ucr_link_s link;
  logic [5:0] inEvents, outEvents;
  logic [7:0] rdData;
  logic [6:0] deviceAddress;
  logic [3:0] endpointSelect;
  logic isoZeroLength, resumeDrive, fifoFlush, suspended, intRequest;
  int err_total = 0, comparisons = 0;
  logic [23:0] rstTab [8] = '{24'h620000, 24'h620100, 24'h620200, 24'h620400, 24'h620600,
    24'h62073f, 24'h620300, 24'h623000};
  always begin
    #5;
    sys_clk = ~sys_clk;
  end
  ucr_regs #(.IDLE_CYC(20)) u_ucr_regs (.sys_clk(sys_clk), .rst_n(rst_n),
    .deepPowerEntry(deepPowerEntry), .cpuBus(cpuBus), .rdData(rdData), .link(link),
    .inEvents(inEvents), .outEvents(outEvents), .isoInLoaded(isoInLoaded),
    .deviceAddress(deviceAddress), .endpointSelect(endpointSelect), .isoZeroLength(isoZeroLength),
    .resumeDrive(resumeDrive), .fifoFlush(fifoFlush), .suspended(suspended),
    .intRequest(intRequest));
  ucr_usb_host u_ucr_usb_host (.sys_clk(sys_clk), .link(link), .inEvents(inEvents),
    .outEvents(outEvents), .isoInLoaded(isoInLoaded));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    cpuBus = {2'h2, a, d};
    @(negedge sys_clk);
    cpuBus = '0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic [5:0] ev = 6'h00);
    @(negedge sys_clk);
    cpuBus = {2'h1, a, 8'h00};
    u_ucr_usb_host.set_events(ev, 6'h00, 1'b0);
    @(negedge sys_clk);
    cpuBus = '0;
    u_ucr_usb_host.set_events(6'h00, 6'h00, 1'b0);
    chk(rdData, exp);
  endtask
  task automatic pulse(input logic [5:0] i, input logic [5:0] o, input logic iso = 1'b0);
    @(negedge sys_clk);
    u_ucr_usb_host.set_events(i, o, iso);
    @(negedge sys_clk);
    u_ucr_usb_host.set_events(6'h00, 6'h00, 1'b0);
  endtask
  task automatic close_out;
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    close_out;
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1;
    repeat (4) @(negedge sys_clk);
    foreach (rstTab[i]) rd(rstTab[i][23:8], rstTab[i][7:0]);
    wr(`UCR_OFS_INEN, 8'h00);
    rd(`UCR_OFS_INEN, 8'h00);
    pulse(6'h01, 6'h00);
    chk(8'(intRequest), 8'h00);
    rd(`UCR_OFS_INFLG, 8'h01);
    wr(`UCR_OFS_INEN, 8'h3f);
    pulse(6'h21, 6'h3f);
    chk(8'(intRequest), 8'h01);
    rd(`UCR_OFS_OUTFLG, 8'h3e);
    rd(`UCR_OFS_INFLG, 8'h21, 6'h02);
    rd(`UCR_OFS_INFLG, 8'h02);
    rd(`UCR_OFS_INFLG, 8'h00);
    wr(`UCR_OFS_ADDR, 8'h05);
    rd(`UCR_OFS_ADDR, 8'h85);
    u_ucr_usb_host.put(5'h01);
    u_ucr_usb_host.put(5'h00);
    rd(`UCR_OFS_ADDR, 8'h05);
    wr(`UCR_OFS_SEL, 8'h03);
    chk(8'(endpointSelect), 8'h03);
    u_ucr_usb_host.put(5'h08);
    rd(`UCR_OFS_POW, 8'h08);
    chk(8'(fifoFlush), 8'h01);
    u_ucr_usb_host.put(5'h00);
    rd(`UCR_OFS_POW, 8'h00);
    chk(8'(deviceAddress), 8'h00);
    chk(8'(endpointSelect), 8'h00);
    u_ucr_usb_host.put(5'h14);
    u_ucr_usb_host.put(5'h00);
    rd(`UCR_OFS_COMFLG, 8'h0e);
    u_ucr_usb_host.put(5'h02);
    repeat (30) @(negedge sys_clk);
    chk(8'(suspended), 8'h00);
    wr(`UCR_OFS_POW, 8'h01);
    repeat (30) @(negedge sys_clk);
    rd(`UCR_OFS_POW, 8'h03);
    u_ucr_usb_host.put(5'h00);
    rd(`UCR_OFS_COMFLG, 8'h01);
    chk(8'(suspended), 8'h00);
    wr(`UCR_OFS_POW, 8'h05);
    chk(8'(resumeDrive), 8'h01);
    repeat (10) @(negedge sys_clk);
    wr(`UCR_OFS_POW, 8'h80);
    chk(8'(resumeDrive), 8'h00);
    pulse(6'h00, 6'h00, 1'b1);
    chk(8'(isoZeroLength), 8'h01);
    u_ucr_usb_host.put(5'h10);
    u_ucr_usb_host.put(5'h00);
    chk(8'(isoZeroLength), 8'h00);
    wr(`UCR_OFS_ADDR, 8'h07);
    @(negedge sys_clk);
    deepPowerEntry = 1;
    @(negedge sys_clk);
    deepPowerEntry = 0;
    chk(8'(fifoFlush), 8'h01);
    repeat (4) @(negedge sys_clk);
    chk(8'(deviceAddress), 8'h00);
    rd(`UCR_OFS_POW, 8'h00);
    close_out;
  end
endmodule
